// file: hdl/srp_dev.sv
// Serdes receive power, recovery and serial PLL register bank
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "srp_regs.svh"
module srp_dev
  import srp_pkg::*;
(
  // Clock and reset
  input  wire logic       SYS_CLK_I,
  input  wire logic       RSTN_I,
  // Register link
  srp_cfg_if.dev          cfg,
  // Analog front end controls
  output logic            MAIN_RX_POWER_OFF_O,
  output logic [7:0]      LANE_POWER_OFF_MASK_O,
  output logic            SYNC_PAIR0_BUFFER_OFF_O,
  output logic            SYNC_PAIR1_BUFFER_OFF_O,
  output logic            RECOVERY_RESET_LOW_O,
  output logic            RECOVERY_HALF_SPEED_O,
  output logic            RECOVERY_OVERSAMPLE_ON_O,
  output logic [1:0]      EQUALIZER_POWER_SETTING_O,
  // Serial PLL controls and sense
  output logic            PLL_CURRENTS_ON_O,
  output logic            PLL_CAL_START_O,
  input  wire logic       PUMP_HIGH_I,
  input  wire logic       PUMP_LOW_I,
  input  wire logic       OSC_OUTPUT_LEVEL_SELECT_I,
  input  wire logic       PLL_LOCK_RAW_I,
  input  wire logic [1:0] LOCK_COUNT_SEL_I
);

  srp_dev_s s_ff;
  srp_dev_s nxt_s;
  logic     en_rise;
  logic     recal_rise;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lock_target(input logic [1:0] sel);
    lock_target = `SRP_LOCK_BASE << sel;
  endfunction : lock_target

  function automatic logic [7:0] readback(input srp_dev_s s,
                                          input logic [9:0] a);
    case (a)
      `SRP_A_RX_MAIN_POWER_DOWN:  readback = {7'h00, s.main_off};
      `SRP_A_LANE_PD:  readback = s.lane_off;
      `SRP_A_SYNC_PD:  readback = {6'h00, s.sync_off};
      `SRP_A_CDR_RST:  readback = {7'h00, s.cdr_rstn};
      `SRP_A_CDR_MODE: readback = s.mode;
      `SRP_A_EQ_BIAS:  readback = s.eq;
      `SRP_A_PLL_CTL:  readback = {5'h00, s.pll_ctl[2:0]};
      `SRP_A_PLL_STAT: readback = {2'h0, s.status};
      default:         readback = 8'h00;
    endcase
  endfunction : readback

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_s      = s_ff;
    nxt_s.rdata = 8'h00;
    nxt_s.cal_go = 1'b0;
    en_rise    = s_ff.pll_ctl[`SRP_B_EN] & ~s_ff.en_prev;
    recal_rise = s_ff.pll_ctl[`SRP_B_RECAL] & ~s_ff.recal_prev;
    nxt_s.en_prev    = s_ff.pll_ctl[`SRP_B_EN];
    nxt_s.recal_prev = s_ff.pll_ctl[`SRP_B_RECAL];

    if (cfg.wr) begin
      case (cfg.addr)
        `SRP_A_RX_MAIN_POWER_DOWN:  nxt_s.main_off = cfg.wdata[0];
        `SRP_A_LANE_PD:  nxt_s.lane_off = cfg.wdata;
        `SRP_A_SYNC_PD:  nxt_s.sync_off = cfg.wdata[1:0];
        `SRP_A_CDR_RST:  nxt_s.cdr_rstn = cfg.wdata[0];
        `SRP_A_CDR_MODE: nxt_s.mode = cfg.wdata;
        `SRP_A_EQ_BIAS:  nxt_s.eq = cfg.wdata;
        `SRP_A_PLL_CTL:  nxt_s.pll_ctl = {5'h00, cfg.wdata[2:0]};
        default: ; // Status and unmapped writes dropped
      endcase
    end
    if (cfg.rd) begin
      nxt_s.rdata = readback(s_ff, cfg.addr);
    end

    // Calibration sequencer
    case (s_ff.cal)
      CAL_IDLE: begin
        if (en_rise) begin
          nxt_s.cal = CAL_BIAS;
          nxt_s.cnt = `SRP_BIAS_CYC;
        end
      end
      CAL_BIAS: begin
        nxt_s.cnt = s_ff.cnt - 16'h0001;
        if (s_ff.cnt == 16'h0001) begin
          nxt_s.cal    = CAL_OSC;
          nxt_s.cnt    = `SRP_OSC_CYC;
          nxt_s.cal_go = 1'b1;
        end
      end
      CAL_OSC: begin
        nxt_s.cnt = s_ff.cnt - 16'h0001;
        if (s_ff.cnt == 16'h0001) begin
          nxt_s.cal = CAL_PUMP;
          nxt_s.cnt = `SRP_PUMP_CYC;
        end
      end
      CAL_PUMP: begin
        nxt_s.cnt = s_ff.cnt - 16'h0001;
        if (s_ff.cnt == 16'h0001) begin
          nxt_s.cal      = CAL_RUN;
          nxt_s.lock_cnt = 16'h0000;
        end
      end
      CAL_RUN: begin
        // Lock must hold unbroken; any slip restarts the count
        if (!PLL_LOCK_RAW_I) begin
          nxt_s.lock_cnt = 16'h0000;
        end else if (s_ff.lock_cnt != 16'hFFFF) begin
          nxt_s.lock_cnt = s_ff.lock_cnt + 16'h0001;
        end
      end
      default: nxt_s.cal = CAL_IDLE;
    endcase

    // Recalibration restarts from the oscillator step, bias stays up
    if (recal_rise && s_ff.pll_ctl[`SRP_B_EN] &&
        (s_ff.cal != CAL_IDLE) && (s_ff.cal != CAL_BIAS)) begin
      nxt_s.cal      = CAL_OSC;
      nxt_s.cnt      = `SRP_OSC_CYC;
      nxt_s.lock_cnt = 16'h0000;
      nxt_s.cal_go   = 1'b1;
    end
    if (!s_ff.pll_ctl[`SRP_B_EN]) begin
      nxt_s.cal      = CAL_IDLE;
      nxt_s.cnt      = 16'h0000;
      nxt_s.lock_cnt = 16'h0000;
    end

    // Live flags; range flags gated because they mean nothing otherwise
    nxt_s.status[5] = PUMP_HIGH_I & ~OSC_OUTPUT_LEVEL_SELECT_I;
    nxt_s.status[4] = PUMP_LOW_I & ~OSC_OUTPUT_LEVEL_SELECT_I;
    nxt_s.status[3] = (s_ff.cal == CAL_RUN);
    nxt_s.status[2] = (s_ff.cal == CAL_OSC);
    nxt_s.status[1] = (s_ff.cal != CAL_IDLE) &&
                      (s_ff.cal != CAL_BIAS);
    nxt_s.status[0] = (s_ff.cal == CAL_RUN) &&
                      (s_ff.lock_cnt >= lock_target(LOCK_COUNT_SEL_I));

    // Main bit overrides every lane
    nxt_s.lane_pd = nxt_s.lane_off | {8{nxt_s.main_off}};
  end

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      s_ff          <= '0;
      s_ff.main_off <= `SRP_RST_MAIN;
      s_ff.lane_off <= `SRP_RST_LANE;
      s_ff.lane_pd  <= {8{`SRP_RST_MAIN}};
      s_ff.sync_off <= `SRP_RST_SYNC;
      s_ff.cdr_rstn <= `SRP_RST_CDR;
      s_ff.mode     <= `SRP_RST_MODE;
      s_ff.eq       <= `SRP_RST_EQ;
      s_ff.pll_ctl  <= `SRP_RST_PLL;
      s_ff.cal      <= CAL_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign cfg.rdata                 = s_ff.rdata;
  assign MAIN_RX_POWER_OFF_O       = s_ff.main_off;
  assign LANE_POWER_OFF_MASK_O     = s_ff.lane_pd;
  assign SYNC_PAIR0_BUFFER_OFF_O   = s_ff.sync_off[1];
  assign SYNC_PAIR1_BUFFER_OFF_O   = s_ff.sync_off[0];
  assign RECOVERY_RESET_LOW_O      = s_ff.cdr_rstn;
  assign RECOVERY_HALF_SPEED_O     = s_ff.mode[`SRP_B_HALF];
  assign RECOVERY_OVERSAMPLE_ON_O  = s_ff.mode[`SRP_B_OVS];
  assign EQUALIZER_POWER_SETTING_O = s_ff.eq[`SRP_F_EQ_HI:`SRP_F_EQ_LO];
  assign PLL_CURRENTS_ON_O         = s_ff.pll_ctl[`SRP_B_EN];
  assign PLL_CAL_START_O           = s_ff.cal_go;

endmodule : srp_dev
`default_nettype wire

// file: hdl/srp_regs.svh
// Register map, reset values and timing counts for the serdes receive block
`ifndef SRP_REGS_SVH
`define SRP_REGS_SVH

// Device configuration map
`define SRP_A_RX_MAIN_POWER_DOWN     10'h200
`define SRP_A_LANE_PD     10'h201
`define SRP_A_SYNC_PD     10'h203
`define SRP_A_CDR_RST     10'h206
`define SRP_A_CDR_MODE    10'h230
`define SRP_A_EQ_BIAS     10'h268
`define SRP_A_PLL_CTL     10'h280
`define SRP_A_PLL_STAT    10'h281

// Reset values
`define SRP_RST_MAIN      1'h1
`define SRP_RST_LANE      8'h00
`define SRP_RST_SYNC      2'h0
`define SRP_RST_CDR       1'h1
`define SRP_RST_MODE      8'h20
`define SRP_RST_EQ        8'h72
`define SRP_RST_PLL       8'h00

// Field positions
`define SRP_B_HALF        5
`define SRP_B_OVS         1
`define SRP_B_RECAL       2
`define SRP_B_EN          0
`define SRP_F_EQ_HI       7
`define SRP_F_EQ_LO       6

// Calibration step lengths and lock count base in cycles
`define SRP_BIAS_CYC      16'h0040
`define SRP_OSC_CYC       16'h0100
`define SRP_PUMP_CYC      16'h0080
`define SRP_LOCK_BASE     16'h0040

// Host command registers
`define SRP_H_CTRL        4'h0
`define SRP_H_RATE        4'h1
`define SRP_H_RADDR       4'h2
`define SRP_H_RDATA       4'h3
`define SRP_H_STAT        4'h4
`define SRP_H_ISTAT       4'h5
`define SRP_H_IMASK       4'h6
`define SRP_C_BRINGUP     0
`define SRP_C_RECAL       1
`define SRP_C_RAWWR       2
`define SRP_C_RAWRD       3
`define SRP_I_DONE        0
`define SRP_I_RDDONE      1

// Lane rate thresholds in Mbps
`define SRP_HALF_MIN      16'h1770
`define SRP_OVS_MIN       16'h05A0
`define SRP_OVS_MAX       16'h0B40

`endif

// file: hdl/srp_pkg.sv
// Types shared by both ends of the serdes receive configuration link
`default_nettype none
package srp_pkg;

  typedef enum logic [4:0] {
    CAL_IDLE = 5'h01,
    CAL_BIAS = 5'h02,
    CAL_OSC  = 5'h04,
    CAL_PUMP = 5'h08,
    CAL_RUN  = 5'h10
  } srp_cal_e;

  typedef enum logic [7:0] {
    H_IDLE  = 8'h01,
    H_MODE  = 8'h02,
    H_EN    = 8'h04,
    H_RCLO  = 8'h08,
    H_RD1   = 8'h10,
    H_RD2   = 8'h20,
    H_FIN   = 8'h40,
    H_FINRD = 8'h80
  } srp_host_e;

  typedef struct packed {
    logic       main_off;
    logic [7:0] lane_off;
    logic [7:0] lane_pd;
    logic [1:0] sync_off;
    logic       cdr_rstn;
    logic [7:0] mode;
    logic [7:0] eq;
    logic [7:0] pll_ctl;
    logic       en_prev;
    logic       recal_prev;
    logic       cal_go;
    srp_cal_e   cal;
    logic [15:0] cnt;
    logic [15:0] lock_cnt;
    logic [5:0] status;
    logic [7:0] rdata;
  } srp_dev_s;

  typedef struct packed {
    srp_host_e  st;
    logic [15:0] rate;
    logic [9:0] raddr;
    logic [7:0] rdat;
    logic       pll_on;
    logic [1:0] istat;
    logic [1:0] imask;
    logic       irq;
    logic [15:0] udata;
    logic [9:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } srp_host_s;

endpackage : srp_pkg
`default_nettype wire

// file: hdl/srp_cfg_if.sv
// Register link between the configuring host and the serdes receive block
`timescale 1ns/10ps
`default_nettype none
interface srp_cfg_if;
  logic [9:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;

  modport dev  (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd,
                input rdata);
endinterface : srp_cfg_if
`default_nettype wire

// file: hdl/srp_host.sv
// Host end: runs bring-up, recalibration and raw accesses on the link
`timescale 1ns/10ps
`default_nettype none
`include "srp_regs.svh"
module srp_host
  import srp_pkg::*;
(
  // Clock and reset
  input  wire logic        SYS_CLK_I,
  input  wire logic        RSTN_I,
  // Software port
  input  wire logic [3:0]  ADDR_I,
  input  wire logic [15:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic [15:0]      RDATA_O,
  output logic             IRQ_O,
  // Register link
  srp_cfg_if.host          cfg
);

  srp_host_s s_ff;
  srp_host_s nxt_s;
  logic [1:0] ev;

  ////////////////////////////////////////////////////////////////////////
  // Mode byte chosen from the lane rate in Mbps
  function automatic logic [7:0] mode_for(input logic [15:0] r);
    mode_for = 8'h00;
    mode_for[`SRP_B_HALF] = (r > `SRP_HALF_MIN);
    mode_for[`SRP_B_OVS]  = (r >= `SRP_OVS_MIN) && (r <= `SRP_OVS_MAX);
  endfunction : mode_for

  function automatic logic [7:0] pll_byte(input logic on,
                                          input logic recal);
    pll_byte = 8'h00;
    pll_byte[`SRP_B_EN]    = on;
    pll_byte[`SRP_B_RECAL] = recal;
  endfunction : pll_byte

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_s       = s_ff;
    nxt_s.wr    = 1'b0;
    nxt_s.rd    = 1'b0;
    nxt_s.udata = 16'h0000;
    ev          = 2'h0;

    case (s_ff.st)
      H_IDLE: begin
        if (WR_I && (ADDR_I == `SRP_H_CTRL)) begin
          if (WDATA_I[`SRP_C_BRINGUP]) begin
            nxt_s.addr  = `SRP_A_CDR_MODE;
            nxt_s.wdata = mode_for(s_ff.rate);
            nxt_s.wr    = 1'b1;
            nxt_s.st    = H_EN;
          end else if (WDATA_I[`SRP_C_RECAL]) begin
            nxt_s.addr  = `SRP_A_PLL_CTL;
            nxt_s.wdata = pll_byte(s_ff.pll_on, 1'b1);
            nxt_s.wr    = 1'b1;
            nxt_s.st    = H_RCLO;
          end else if (WDATA_I[`SRP_C_RAWWR]) begin
            nxt_s.addr  = s_ff.raddr;
            nxt_s.wdata = s_ff.rdat;
            nxt_s.wr    = 1'b1;
            nxt_s.st    = H_FIN;
          end else if (WDATA_I[`SRP_C_RAWRD]) begin
            nxt_s.addr = s_ff.raddr;
            nxt_s.rd   = 1'b1;
            nxt_s.st   = H_RD1;
          end
        end
      end
      H_EN: begin
        // Mode first, enable last, so the PLL starts on a set-up link
        nxt_s.addr   = `SRP_A_PLL_CTL;
        nxt_s.wdata  = pll_byte(1'b1, 1'b0);
        nxt_s.wr     = 1'b1;
        nxt_s.pll_on = 1'b1;
        nxt_s.st     = H_FIN;
      end
      H_RCLO: begin
        nxt_s.wdata = pll_byte(s_ff.pll_on, 1'b0);
        nxt_s.wr    = 1'b1;
        nxt_s.st    = H_FIN;
      end
      H_RD1: nxt_s.st = H_RD2;
      H_RD2: begin
        nxt_s.rdat = cfg.rdata;
        nxt_s.st   = H_FINRD;
      end
      H_FIN: begin
        ev[`SRP_I_DONE] = 1'b1;
        nxt_s.st        = H_IDLE;
      end
      H_FINRD: begin
        ev[`SRP_I_RDDONE] = 1'b1;
        nxt_s.st          = H_IDLE;
      end
      default: nxt_s.st = H_IDLE;
    endcase

    if (WR_I) begin
      case (ADDR_I)
        `SRP_H_RATE:  nxt_s.rate = WDATA_I;
        `SRP_H_RADDR: nxt_s.raddr = WDATA_I[9:0];
        `SRP_H_RDATA: nxt_s.rdat = WDATA_I[7:0];
        `SRP_H_ISTAT: nxt_s.istat = s_ff.istat & ~WDATA_I[1:0];
        `SRP_H_IMASK: nxt_s.imask = WDATA_I[1:0];
        default: ;
      endcase
    end
    // A new event beats a clear in the same cycle
    nxt_s.istat = nxt_s.istat | ev;
    nxt_s.irq   = |(nxt_s.istat & nxt_s.imask);

    if (RD_I) begin
      case (ADDR_I)
        `SRP_H_RATE:  nxt_s.udata = s_ff.rate;
        `SRP_H_RADDR: nxt_s.udata = {6'h00, s_ff.raddr};
        `SRP_H_RDATA: nxt_s.udata = {8'h00, s_ff.rdat};
        `SRP_H_STAT:  nxt_s.udata = {14'h0000, s_ff.pll_on,
                                     s_ff.st != H_IDLE};
        `SRP_H_ISTAT: nxt_s.udata = {14'h0000, s_ff.istat};
        `SRP_H_IMASK: nxt_s.udata = {14'h0000, s_ff.imask};
        default:      nxt_s.udata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      s_ff    <= '0;
      s_ff.st <= H_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign cfg.addr  = s_ff.addr;
  assign cfg.wdata = s_ff.wdata;
  assign cfg.wr    = s_ff.wr;
  assign cfg.rd    = s_ff.rd;
  assign RDATA_O   = s_ff.udata;
  assign IRQ_O     = s_ff.irq;

endmodule : srp_host
`default_nettype wire

// file: sim/srp_cfg_asserts.sv
// Concurrent checks on the link between host end and register bank
`timescale 1ns/10ps
`default_nettype none
`include "srp_regs.svh"
module srp_cfg_asserts (
  // Clock and reset
  input wire logic       SYS_CLK_I,
  input wire logic       RSTN_I,
  // Link signals
  input wire logic [9:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata
);
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RSTN_I);

  ////////////////////////////////////////////////////////////////
  sequence s_recal_up;
    wr && addr == `SRP_A_PLL_CTL && wdata[`SRP_B_RECAL];
  endsequence
  sequence s_recal_down;
    wr && addr == `SRP_A_PLL_CTL && !wdata[`SRP_B_RECAL];
  endsequence
  sequence s_enable_set;
    wr && addr == `SRP_A_PLL_CTL && wdata[`SRP_B_EN] && !wdata[`SRP_B_RECAL];
  endsequence
  // Reserved bits of a read register come back as zero
  property p_rsv(logic [9:0] a, logic [7:0] m);
    rd && addr == a |=> (rdata & m) == 8'h00;
  endproperty

  a_rdata_idle_zero: assert property (
    !$past(rd) |-> rdata == 8'h00)
    else $error("read data present without a read");
  a_strobes_exclusive: assert property (!(wr && rd))
    else $error("write and read strobes together");
  a_recal_bit_drop: assert property (s_recal_up |=> s_recal_down)
    else $error("recalibrate bit not dropped after raising");
  a_mode_before_enable: assert property (
    s_enable_set and !$past(wr && addr == `SRP_A_PLL_CTL)
    |-> $past(wr && addr == `SRP_A_CDR_MODE))
    else $error("pll enabled before operating mode set");
  a_main_rsv_zero: assert property (p_rsv(`SRP_A_RX_MAIN_POWER_DOWN, 8'hFE))
    else $error("main power register upper bits nonzero");
  a_sync_rsv_zero: assert property (p_rsv(`SRP_A_SYNC_PD, 8'hFC))
    else $error("sync buffer register upper bits nonzero");
  a_cdr_rsv_zero: assert property (p_rsv(`SRP_A_CDR_RST, 8'hFE))
    else $error("recovery reset register upper bits nonzero");
  a_ctl_rsv_zero: assert property (p_rsv(`SRP_A_PLL_CTL, 8'hF8))
    else $error("pll control upper bits nonzero");
  a_stat_rsv_zero: assert property (p_rsv(`SRP_A_PLL_STAT, 8'hC0))
    else $error("pll status upper bits nonzero");
endmodule : srp_cfg_asserts
`default_nettype wire

// file: sim/tb_serdes_rx_phy_pll_control_regs.sv
// Bench driving the host software port and watching both link ends
`timescale 1ns/10ps
`default_nettype none
module tb_serdes_rx_phy_pll_control_regs;
  logic        clk, rstn, wr, rd, irq, rd_seen;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata;
  logic        main_o, sync0_o, sync1_o, rstl_o, half_o, ovs_o, cur_o, cal_o;
  logic [7:0]  lane_o, rnd;
  logic [1:0]  eq_o, lsel;
  logic        p_hi, p_lo, lvl, lock;
  logic [15:0] exp_q[$];
  string       nm_q[$];
  int          bad_count, checks, cyc, cal_n;
  logic [9:0]  ra[8] = '{10'h200, 10'h201, 10'h203, 10'h206, 10'h230,
                         10'h268, 10'h280, 10'h281};
  logic [7:0]  rv[8] = '{8'h01, 8'h00, 8'h00, 8'h01, 8'h20, 8'h72, 8'h00,
                         8'h00};
  logic [15:0] rate[6] = '{16'h1770, 16'h1771, 16'h059F, 16'h05A0, 16'h0B40,
                           16'h0B41};

  srp_cfg_if cfg ();
  srp_dev i_srp_dev (
    .SYS_CLK_I(clk), .RSTN_I(rstn), .cfg(cfg),
    .MAIN_RX_POWER_OFF_O(main_o), .LANE_POWER_OFF_MASK_O(lane_o),
    .SYNC_PAIR0_BUFFER_OFF_O(sync0_o), .SYNC_PAIR1_BUFFER_OFF_O(sync1_o),
    .RECOVERY_RESET_LOW_O(rstl_o), .RECOVERY_HALF_SPEED_O(half_o),
    .RECOVERY_OVERSAMPLE_ON_O(ovs_o), .EQUALIZER_POWER_SETTING_O(eq_o),
    .PLL_CURRENTS_ON_O(cur_o), .PLL_CAL_START_O(cal_o), .PUMP_HIGH_I(p_hi),
    .PUMP_LOW_I(p_lo), .OSC_OUTPUT_LEVEL_SELECT_I(lvl),
    .PLL_LOCK_RAW_I(lock), .LOCK_COUNT_SEL_I(lsel));
  srp_host i_srp_host (
    .SYS_CLK_I(clk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .IRQ_O(irq), .cfg(cfg));
  srp_cfg_asserts i_srp_cfg_asserts (
    .SYS_CLK_I(clk), .RSTN_I(rstn), .addr(cfg.addr), .wdata(cfg.wdata),
    .wr(cfg.wr), .rd(cfg.rd), .rdata(cfg.rdata));

  always #4 clk = ~clk;
  always @(posedge clk) rd_seen <= rd;
  always @(posedge clk) if (cal_o === 1'b1) cal_n <= cal_n + 1;
  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end
  // Read data stand only in the cycle after the strobe
  always @(negedge clk) if (rd_seen === 1'b1) chk(nm_q.pop_front(), rdata,
    exp_q.pop_front());

  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic hw(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : hw
  task automatic hr(input logic [3:0] a, input logic [15:0] e,
                    input string nm);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    exp_q.push_back(e);
    nm_q.push_back(nm);
    @(posedge clk);
    rd <= 1'b0;
  endtask : hr
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk("irq_wait", {15'h0000, irq}, 16'h0001);
    hw(4'h5, 16'h0003);
  endtask : wait_irq
  task automatic raw_wr(input logic [9:0] a, input logic [7:0] d);
    hw(4'h2, {6'h00, a});
    hw(4'h3, {8'h00, d});
    hw(4'h0, 16'h0004);
    wait_irq();
  endtask : raw_wr
  task automatic raw_rd(input logic [9:0] a, input logic [7:0] e,
                        input string nm);
    hw(4'h2, {6'h00, a});
    hw(4'h0, 16'h0008);
    wait_irq();
    hr(4'h3, {8'h00, e}, nm);
  endtask : raw_rd
  task automatic final_report();
    $display("Checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////
  initial begin
    {clk, rstn, wr, rd, p_hi, p_lo, lvl, lock} = 8'h00;
    addr = 4'h0;
    wdata = 16'h0000;
    lsel = 2'h0;
    {bad_count, checks, cyc, cal_n} = '0;
    void'($urandom(18));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    chk("main_off", {15'h0000, main_o}, 16'h0001);
    chk("lanes", {8'h00, lane_o}, 16'h00FF);
    chk("half", {15'h0000, half_o}, 16'h0001);
    chk("ovs", {15'h0000, ovs_o}, 16'h0000);
    chk("eq", {14'h0000, eq_o}, 16'h0001);
    chk("cdr_rstn", {15'h0000, rstl_o}, 16'h0001);
    hw(4'h6, 16'h0003);
    foreach (ra[i]) raw_rd(ra[i], rv[i], "reset_val");
    rnd = 8'($urandom());
    raw_wr(10'h201, rnd);
    chk("lanes_main", {8'h00, lane_o}, 16'h00FF);
    raw_wr(10'h200, 8'hFF);
    raw_rd(10'h200, 8'h01, "main_rb");
    raw_wr(10'h200, 8'h00);
    chk("lanes_mask", {8'h00, lane_o}, {8'h00, rnd});
    raw_wr(10'h203, 8'hFE);
    chk("sync0", {15'h0000, sync0_o}, 16'h0001);
    chk("sync1", {15'h0000, sync1_o}, 16'h0000);
    raw_rd(10'h203, 8'h02, "sync_rb");
    raw_wr(10'h206, 8'h00);
    chk("cdr_hold", {15'h0000, rstl_o}, 16'h0000);
    raw_wr(10'h206, 8'hFF);
    raw_rd(10'h206, 8'h01, "cdr_rb");
    raw_wr(10'h268, rnd);
    chk("eq_set", {14'h0000, eq_o}, {14'h0000, rnd[7:6]});
    raw_wr(10'h281, 8'hFF);
    raw_rd(10'h281, 8'h00, "stat_ro");
    raw_rd(10'h3FF, 8'h00, "unmapped");
    lock <= 1'b1;
    p_hi <= 1'b1;
    foreach (rate[i]) begin
      hw(4'h1, rate[i]);
      hw(4'h0, 16'h0001);
      wait_irq();
      chk("half_set", {15'h0000, half_o},
          {15'h0000, rate[i] > 16'h1770});
      chk("ovs_set", {15'h0000, ovs_o},
          {15'h0000, rate[i] >= 16'h05A0 && rate[i] <= 16'h0B40});
    end
    chk("currents", {15'h0000, cur_o}, 16'h0001);
    repeat (700) @(posedge clk);
    chk("cal_starts", 16'(cal_n), 16'h0001);
    raw_rd(10'h281, 8'h2B, "locked_hi");
    p_hi <= 1'b0;
    p_lo <= 1'b1;
    raw_rd(10'h281, 8'h1B, "locked_lo");
    lvl <= 1'b1;
    raw_rd(10'h281, 8'h0B, "level_sel");
    // Longest lock count, so the lock flag must wait past 512 cycles
    lsel <= 2'h3;
    hw(4'h0, 16'h0002);
    wait_irq();
    raw_rd(10'h281, 8'h06, "osc_running");
    repeat (700) @(posedge clk);
    chk("recal_starts", 16'(cal_n), 16'h0002);
    raw_rd(10'h281, 8'h0A, "lock_short");
    repeat (300) @(posedge clk);
    raw_rd(10'h281, 8'h0B, "relocked");
    lock <= 1'b0;
    raw_rd(10'h281, 8'h0A, "lock_lost");
    raw_wr(10'h280, 8'h00);
    chk("currents_off", {15'h0000, cur_o}, 16'h0000);
    raw_rd(10'h281, 8'h00, "pll_off");
    hw(4'h6, 16'h0000);
    hw(4'h2, 16'h0200);
    hw(4'h0, 16'h0008);
    repeat (10) @(negedge clk);
    chk("irq_masked", {15'h0000, irq}, 16'h0000);
    hr(4'h5, 16'h0002, "istat");
    hw(4'h6, 16'h0003);
    repeat (2) @(negedge clk);
    chk("irq_on", {15'h0000, irq}, 16'h0001);
    hw(4'h5, 16'h0002);
    repeat (2) @(negedge clk);
    chk("irq_clr", {15'h0000, irq}, 16'h0000);
    hr(4'hF, 16'h0000, "host_unmapped");
    repeat (3) @(posedge clk);
    final_report();
  end
endmodule : tb_serdes_rx_phy_pll_control_regs
`default_nettype wire
